/* accc_pkg.sv */
// package for converter channel and config control
package accc_pkg;
    localparam logic [7:0] OFF_FIRST_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFF_SC1B = 8'h04;
    localparam logic [7:0] OFF_CONVERTER_CONFIG_ONE = 8'h08;
    localparam logic [7:0] OFF_AUX = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam int DONE_BIT = 7;
    localparam int IEN_BIT = 6;
    localparam int PAIRED_INPUT_SELECT_BIT = 5;
    localparam logic [7:0] SC_RESET = 8'h1F;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [4:0] CODE_OFF = 5'h1F;
    localparam logic [4:0] CODE_LAST_PAIR = 5'h03;
    localparam logic [4:0] CODE_LAST_SE = 5'h17;
    localparam logic [4:0] CODE_TEMP = 5'h1A;
    localparam logic [4:0] CODE_BGAP = 5'h1B;
    localparam logic [4:0] CODE_VRH = 5'h1D;
    localparam logic [4:0] CODE_VRL = 5'h1E;
    localparam logic [5:0] SAMPLE_SHORT = 6'h04;
    localparam logic [5:0] LS_TOTAL_0 = 6'h18;
    localparam logic [5:0] LS_TOTAL_1 = 6'h10;
    localparam logic [5:0] LS_TOTAL_2 = 6'h0A;
    localparam logic [5:0] LS_TOTAL_3 = 6'h06;
    localparam logic [4:0] BITS_SE_0 = 5'h08;
    localparam logic [4:0] BITS_SE_1 = 5'h0C;
    localparam logic [4:0] BITS_SE_2 = 5'h0A;
    localparam logic [4:0] BITS_16 = 5'h10;
    localparam logic [4:0] BITS_DF_0 = 5'h09;
    localparam logic [4:0] BITS_DF_1 = 5'h0D;
    localparam logic [4:0] BITS_DF_2 = 5'h0B;
    localparam logic [4:0] PAIRED_INPUT_SELECT_EXTRA = 5'h04;
    localparam logic [7:0] ASYNC_START = 8'h05;
    typedef struct packed {
        logic done;
        logic irq_en;
        logic paired_input_select;
        logic [4:0] chan;
    } accc_sc_type;
    typedef struct packed {
        logic low_power;
        logic [1:0] div;
        logic long_sample;
        logic [1:0] mode;
        logic [1:0] clk_src;
    } accc_cfg_type;
    typedef struct packed {
        logic [4:0] chan;
        logic paired_input_select;
        logic reserved;
        logic powered;
    } accc_mux_type;
endpackage : accc_pkg

/* accc_ctrl.sv */
// converter channel, config and sequencing control with apb registers
// Function
// - done flag set per conversion when compare and averaging off
// - with compare on, done flag set only if compare true
// - with averaging on, done flag set after selected count finishes
// - calibration end sets done flag of first control register
// - writing control register or reading its result clears done flag
// - interrupt asserted when done sets with its enable high
// - paired select uses differential inputs and longer conversion
// - codes 0 to 3 pick pair plus pin or whole pair
// - codes 4 to 23 single-ended only; 24,25,28 always reserved
// - code 26 temperature sensor, 27 bandgap, either mode
// - 29 high reference or negation, 30 low reference single only
// - code 31 powers off, isolates input, starts no conversion
// - without continuous mode, power down after conversion ends
// - low power bit trades clock speed for power
// - divide field divides input clock by 1, 2, 4 or 8
// - sample bit picks short or long sample, length field extends
// - resolution codes map 8,12,10,16 or 9,13,11,16 bits
// - clock source field picks clock that feeds the divider
// - async clock runs only during conversions and calibration unless output enabled
// - status control bits 31 to 8 read zero
// - source codes are bus, half bus, alternate, async clocks
// - long sample lengths 24, 16, 10, 6 cycles total
// - write to first register starts conversion unless code all ones or hardware trigger selected; here only when idle, a write mid-conversion starts none
// - write to controlling register aborts its conversion
//
// Chosen here: the APB register port.
module accc_ctrl
    import accc_pkg::*;
#(
    parameter int CYCLES_PER_BIT = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alt_clk_tick,
    input wire logic async_clk_tick,
    input wire logic hw_trigger,
    input wire logic hw_trigger_sel,
    input wire logic compare_true,
    output logic done_irq,
    output accc_mux_type mux_ctrl,
    output logic converter_clock,
    output logic async_clock_run,
    output logic sample_phase,
    output logic [4:0] result_bits,
    output logic low_power_out
);
    initial begin
        if (CYCLES_PER_BIT < 1) $error("CYCLES_PER_BIT must be positive");
    end

    typedef enum {ST_IDLE, ST_WAKE, ST_SAMPLE, ST_CONVERT, ST_CAL} accc_st_type;

    accc_sc_type sc_reg [2];
    accc_cfg_type cfg_reg;
    logic cont_reg, cmp_en_reg, avg_en_reg, async_oe_reg;
    logic [1:0] avg_sel_reg, ls_len_reg;
    logic cal_reg;
    accc_st_type st_reg;
    logic active_reg;
    logic [7:0] cnt_reg;
    logic [5:0] avg_cnt_reg;
    logic [2:0] div_reg;
    logic half_reg;
    logic tick_reg;

    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic rd = acc && !pwrite;
    wire logic wr_sc0 = wr && paddr == OFF_FIRST_STATUS_CONTROL;
    wire logic wr_sc1 = wr && paddr == OFF_SC1B;
    wire logic rd_res0 = rd && paddr == OFF_STAT;
    wire logic rd_res1 = rd && paddr == 8'h14;
    wire logic mapped = paddr == OFF_FIRST_STATUS_CONTROL || paddr == OFF_SC1B
        || paddr == OFF_CONVERTER_CONFIG_ONE || paddr == OFF_AUX || paddr == OFF_STAT
        || paddr == 8'h14;

    // selected clock source tick, then divider
    logic src_tick;
    always_comb begin
        case (cfg_reg.clk_src)
            2'b00: src_tick = 1'b1;
            2'b01: src_tick = half_reg;
            2'b10: src_tick = alt_clk_tick;
            default: src_tick = async_clk_tick && async_clock_run;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            half_reg <= 1'b0;
        end else if (st_reg == ST_IDLE) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= !half_reg;
        end
    end

    logic [2:0] div_max;
    always_comb begin
        case (cfg_reg.div)
            2'b00: div_max = 3'h0;
            2'b01: div_max = 3'h1;
            2'b10: div_max = 3'h3;
            default: div_max = 3'h7;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            div_reg <= 3'h0;
            tick_reg <= 1'b0;
            converter_clock <= 1'b0;
        end else if (st_reg == ST_IDLE) begin
            div_reg <= 3'h0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (src_tick) begin
                if (div_reg >= div_max) begin
                    div_reg <= 3'h0;
                    tick_reg <= 1'b1;
                    converter_clock <= !converter_clock;
                end else begin
                    div_reg <= div_reg + 3'h1;
                end
            end
        end
    end

    // sample length and conversion length
    logic [5:0] sample_len;
    always_comb begin
        if (!cfg_reg.long_sample) begin
            sample_len = SAMPLE_SHORT;
        end else begin
            case (ls_len_reg)
                2'b00: sample_len = LS_TOTAL_0;
                2'b01: sample_len = LS_TOTAL_1;
                2'b10: sample_len = LS_TOTAL_2;
                default: sample_len = LS_TOTAL_3;
            endcase
        end
    end

    logic act_idx;
    accc_sc_type act_sc;
    logic [4:0] bits;
    always_comb begin
        act_idx = active_reg;
        act_sc = sc_reg[active_reg];
        case (cfg_reg.mode)
            2'b00: bits = act_sc.paired_input_select ? BITS_DF_0 : BITS_SE_0;
            2'b01: bits = act_sc.paired_input_select ? BITS_DF_1 : BITS_SE_1;
            2'b10: bits = act_sc.paired_input_select ? BITS_DF_2 : BITS_SE_2;
            default: bits = BITS_16;
        endcase
    end

    // differential conversions take extra cycles
    logic [7:0] conv_len;
    always_comb begin
        conv_len = 8'(bits) * 8'(CYCLES_PER_BIT);
        if (act_sc.paired_input_select) begin
            conv_len = conv_len + 8'(PAIRED_INPUT_SELECT_EXTRA);
        end
    end

    function automatic logic reserved_code(input accc_sc_type s);
        logic r;
        r = s.chan == 5'h18 || s.chan == 5'h19 || s.chan == 5'h1C;
        if (s.paired_input_select && s.chan > CODE_LAST_PAIR && s.chan <= CODE_LAST_SE) begin
            r = 1'b1;
        end
        if (s.paired_input_select && s.chan == CODE_VRL) begin
            r = 1'b1;
        end
        return r;
    endfunction : reserved_code

    logic avg_target_hit;
    always_comb begin
        case (avg_sel_reg)
            2'b00: avg_target_hit = avg_cnt_reg == 6'h03;
            2'b01: avg_target_hit = avg_cnt_reg == 6'h07;
            2'b10: avg_target_hit = avg_cnt_reg == 6'h0F;
            default: avg_target_hit = avg_cnt_reg == 6'h1F;
        endcase
    end

    wire logic sw_start = wr_sc0 && !hw_trigger_sel
        && pwdata[4:0] != CODE_OFF;
    wire logic hw_start = hw_trigger && hw_trigger_sel
        && sc_reg[1].chan != CODE_OFF;
    wire logic abort = (wr_sc0 && active_reg == 1'b0 || wr_sc1 && active_reg)
        && st_reg != ST_IDLE && st_reg != ST_CAL;
    wire logic conv_end = st_reg == ST_CONVERT && tick_reg
        && cnt_reg == 8'h01;
    wire logic avg_done = !avg_en_reg || avg_target_hit;
    wire logic set_done = conv_end && avg_done
        && (!cmp_en_reg || compare_true);
    wire logic cal_end = st_reg == ST_CAL && tick_reg && cnt_reg == 8'h01;

    // conversion sequencer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 8'h00;
            active_reg <= 1'b0;
            avg_cnt_reg <= 6'h00;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    avg_cnt_reg <= 6'h00;
                    if (cal_reg) begin
                        st_reg <= ST_CAL;
                        cnt_reg <= 8'h40;
                    end else if (sw_start || hw_start) begin
                        active_reg <= sw_start ? 1'b0 : 1'b1;
                        st_reg <= ST_WAKE;
                        cnt_reg <= ASYNC_START;
                    end
                end
                ST_WAKE: begin
                    if (abort) begin
                        st_reg <= ST_IDLE;
                    end else if (cfg_reg.clk_src != 2'b11 || async_oe_reg
                        || cnt_reg == 8'h00) begin
                        st_reg <= ST_SAMPLE;
                        cnt_reg <= {2'b00, sample_len};
                    end else if (tick_reg || async_clk_tick) begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                ST_SAMPLE: begin
                    if (abort) begin
                        st_reg <= ST_IDLE;
                    end else if (tick_reg) begin
                        if (cnt_reg == 8'h01) begin
                            st_reg <= ST_CONVERT;
                            cnt_reg <= conv_len;
                        end else begin
                            cnt_reg <= cnt_reg - 8'h01;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (abort || act_sc.chan == CODE_OFF) begin
                        st_reg <= ST_IDLE;
                    end else if (tick_reg) begin
                        if (cnt_reg == 8'h01) begin
                            avg_cnt_reg <= avg_done ? 6'h00
                                : avg_cnt_reg + 6'h01;
                            if (!avg_done || cont_reg) begin
                                st_reg <= ST_SAMPLE;
                                cnt_reg <= {2'b00, sample_len};
                            end else begin
                                st_reg <= ST_IDLE;
                            end
                        end else begin
                            cnt_reg <= cnt_reg - 8'h01;
                        end
                    end
                end
                ST_CAL: begin
                    if (tick_reg) begin
                        if (cnt_reg == 8'h01) begin
                            st_reg <= ST_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg - 8'h01;
                        end
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // status and control registers, set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sc
            wire logic wr_me = gi == 0 ? wr_sc0 : wr_sc1;
            wire logic rd_me = gi == 0 ? rd_res0 : rd_res1;
            wire logic set_me = set_done && act_idx == gi
                || gi == 0 && cal_end;
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    sc_reg[gi] <= accc_sc_type'(SC_RESET[7:0]);
                end else begin
                    if (wr_me) begin
                        sc_reg[gi].irq_en <= pwdata[IEN_BIT];
                        sc_reg[gi].paired_input_select <= pwdata[PAIRED_INPUT_SELECT_BIT];
                        sc_reg[gi].chan <= pwdata[4:0];
                    end
                    if (set_me) begin
                        sc_reg[gi].done <= 1'b1;
                    end else if (wr_me || rd_me) begin
                        sc_reg[gi].done <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // configuration and auxiliary register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_reg <= accc_cfg_type'(CFG_RESET);
            cont_reg <= 1'b0;
            cmp_en_reg <= 1'b0;
            avg_en_reg <= 1'b0;
            avg_sel_reg <= 2'b00;
            ls_len_reg <= 2'b00;
            async_oe_reg <= 1'b0;
        end else begin
            if (wr && paddr == OFF_CONVERTER_CONFIG_ONE) begin
                cfg_reg <= accc_cfg_type'(pwdata[7:0]);
            end
            if (wr && paddr == OFF_AUX) begin
                cont_reg <= pwdata[0];
                cmp_en_reg <= pwdata[1];
                avg_en_reg <= pwdata[2];
                avg_sel_reg <= pwdata[4:3];
                ls_len_reg <= pwdata[6:5];
                async_oe_reg <= pwdata[7];
            end
        end
    end

    // calibration request, self-clearing once started
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cal_reg <= 1'b0;
        end else if (wr && paddr == OFF_AUX && pwdata[8]) begin
            cal_reg <= 1'b1;
        end else if (st_reg == ST_CAL) begin
            cal_reg <= 1'b0;
        end
    end

    // apb slave, zero wait states
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    OFF_FIRST_STATUS_CONTROL: prdata <= {24'h00_0000, sc_reg[0]};
                    OFF_SC1B: prdata <= {24'h00_0000, sc_reg[1]};
                    OFF_CONVERTER_CONFIG_ONE: prdata <= {24'h00_0000, cfg_reg};
                    OFF_AUX: prdata <= {23'h00_0000, cal_reg, async_oe_reg,
                        ls_len_reg, avg_sel_reg, avg_en_reg, cmp_en_reg,
                        cont_reg};
                    OFF_STAT: prdata <= {26'h000_0000, st_reg == ST_CAL,
                        active_reg, st_reg != ST_IDLE, 3'h0};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // mux, power and interrupt outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mux_ctrl <= '{chan: CODE_OFF, paired_input_select: 1'b0, reserved: 1'b0,
                powered: 1'b0};
            done_irq <= 1'b0;
            async_clock_run <= 1'b0;
            sample_phase <= 1'b0;
            result_bits <= BITS_SE_0;
            low_power_out <= 1'b0;
        end else begin
            mux_ctrl.chan <= act_sc.chan;
            mux_ctrl.paired_input_select <= act_sc.paired_input_select;
            mux_ctrl.reserved <= reserved_code(act_sc);
            mux_ctrl.powered <= st_reg != ST_IDLE && st_reg != ST_CAL
                && act_sc.chan != CODE_OFF;
            done_irq <= sc_reg[0].done && sc_reg[0].irq_en
                || sc_reg[1].done && sc_reg[1].irq_en;
            async_clock_run <= async_oe_reg || cfg_reg.clk_src == 2'b11
                && (sw_start || hw_start || st_reg != ST_IDLE);
            sample_phase <= st_reg == ST_SAMPLE;
            result_bits <= bits;
            low_power_out <= cfg_reg.low_power;
        end
    end

    sequence s_end_done;
        set_done && act_idx == 1'b0;
    endsequence
    a_done_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_end_done |=> sc_reg[0].done)
        else $error("done flag not set after conversion");
    a_cmp_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        conv_end && cmp_en_reg && !compare_true && !cal_end
        && !$past(sc_reg[act_idx].done) |-> !set_done)
        else $error("done set although compare false");
    a_avg_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        set_done && avg_en_reg |-> avg_target_hit)
        else $error("averaging count not reached");
    a_cal_done: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cal_end |=> sc_reg[0].done)
        else $error("calibration did not set done");
    a_wr_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_sc1 && !(set_done && act_idx) |=> !sc_reg[1].done)
        else $error("write did not clear done");
    a_irq_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sc_reg[0].done && sc_reg[0].irq_en |=> done_irq)
        else $error("interrupt missing");
    a_off_nostart: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg == ST_IDLE && wr_sc0 && pwdata[4:0] == CODE_OFF
        && !hw_start && !cal_reg |=> st_reg == ST_IDLE)
        else $error("disable code started conversion");
    a_abort_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        abort |=> st_reg == ST_IDLE)
        else $error("write did not abort");
    a_sc_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pready && $past(paddr) == OFF_FIRST_STATUS_CONTROL |-> prdata[31:8] == 24'h0)
        else $error("upper status bits not zero");
endmodule : accc_ctrl

/* accc_far_model.sv */
// far side model: converter, input mux and clock sources
module accc_far_model
    import accc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire accc_mux_type mux_ctrl,
    input wire logic async_clock_run,
    input wire logic compare_level,
    output logic alt_clk_tick,
    output logic async_clk_tick,
    output logic compare_true
);
    timeunit 1ns;
    timeprecision 1ps;
    logic toggle_reg;
    logic alt_reg;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            toggle_reg <= 1'b0;
        end else begin
            toggle_reg <= ~toggle_reg;
        end
    end
    // alternate source at half rate, phase fixed at power up
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !mux_ctrl.powered) begin
            alt_reg <= 1'b1;
        end else begin
            alt_reg <= ~alt_reg;
        end
    end
    assign alt_clk_tick = alt_reg & mux_ctrl.powered;
    // async source ticks only while requested
    assign async_clk_tick = async_clock_run & toggle_reg;
    // compare level meaningless while unpowered
    assign compare_true = mux_ctrl.powered ? compare_level : toggle_reg;
endmodule : accc_far_model

/* accc_ctrl_tb.sv */
// self-checking bench for converter channel and config control
module accc_ctrl_tb;
    import accc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic alt_clk_tick, async_clk_tick, compare_true, compare_level;
    logic hw_trigger, hw_trigger_sel, done_irq, converter_clock;
    logic async_clock_run, sample_phase, low_power_out;
    logic err_seen, saw_async, rsv;
    logic [4:0] result_bits;
    accc_mux_type mux_ctrl;
    int errors, checks, cnt, dur, d0;
    int bits_tab [8] = '{8, 12, 10, 16, 9, 13, 11, 16};
    int cfg_tab [10] = '{0, 32, 64, 96, 16, 16, 16, 16, 1, 2};
    int aux_tab [10] = '{0, 0, 0, 0, 0, 32, 64, 96, 0, 0};
    int smp_tab [10] = '{4, 8, 16, 32, 24, 16, 10, 6, 8, 8};

    accc_ctrl #(.CYCLES_PER_BIT(1)) u_accc_ctrl (.*);
    accc_far_model u_accc_far_model (.*);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // registered outputs settle one more cycle
        @(posedge sys_clk);
        @(posedge sys_clk);
    endtask : apb

    task automatic run(input logic [31:0] sc, input int lim);
        cnt = 0;
        dur = 0;
        saw_async = 1'b0;
        apb(1'b1, OFF_FIRST_STATUS_CONTROL, sc);
        do begin
            @(posedge sys_clk);
            dur++;
            if (sample_phase === 1'b1) cnt++;
            if (async_clock_run === 1'b1) saw_async = 1'b1;
        end while ((done_irq !== 1'b1 || dur < 2) && dur < lim);
    endtask : run

    task automatic finish_test;
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        #900000;
        errors++;
        finish_test();
    end

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hw_trigger = 1'b0;
        hw_trigger_sel = 1'b0;
        compare_level = 1'b0;
        errors = 0;
        checks = 0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, OFF_FIRST_STATUS_CONTROL, 0);
        chk(rd, 32'h1F);
        apb(1'b0, OFF_SC1B, 0);
        chk(rd, 32'h1F);
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, OFF_FIRST_STATUS_CONTROL, 32'h1F | 32'(d << 5));
            for (int m = 0; m < 4; m++) begin
                apb(1'b1, OFF_CONVERTER_CONFIG_ONE, 32'(m << 2));
                chk(result_bits, bits_tab[d * 4 + m]);
            end
        end
        apb(1'b1, OFF_CONVERTER_CONFIG_ONE, 32'hFFFF_FF80);
        apb(1'b0, OFF_CONVERTER_CONFIG_ONE, 0);
        chk(rd, 32'h80);
        chk(low_power_out, 1'b1);
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, OFF_CONVERTER_CONFIG_ONE, cfg_tab[i]);
            apb(1'b1, OFF_AUX, aux_tab[i]);
            run(32'hFFFF_FF40, 2000);
            chk(cnt, smp_tab[i]);
            chk(done_irq, 1'b1);
            chk(mux_ctrl.powered, 1'b0);
            apb(1'b0, OFF_FIRST_STATUS_CONTROL, 0);
            chk(rd, 32'hC0);
        end
        apb(1'b1, OFF_CONVERTER_CONFIG_ONE, 0);
        run(32'h40, 2000);
        d0 = dur;
        run(32'h60, 2000);
        chk(dur, d0 + BITS_DF_0 - BITS_SE_0 + PAIRED_INPUT_SELECT_EXTRA);
        apb(1'b1, OFF_FIRST_STATUS_CONTROL, 32'h1F);
        apb(1'b0, OFF_FIRST_STATUS_CONTROL, 0);
        chk(rd, 32'h1F);
        chk(done_irq, 1'b0);
        apb(1'b1, OFF_FIRST_STATUS_CONTROL, 32'h40);
        run(32'h5F, 300);
        chk(done_irq, 1'b0);
        chk(mux_ctrl.powered, 1'b0);
        run(32'h40, 2000);
        apb(1'b0, OFF_STAT, 0);
        apb(1'b0, OFF_FIRST_STATUS_CONTROL, 0);
        chk(rd, 32'h40);
        apb(1'b1, OFF_AUX, 32'h2);
        run(32'h40, 300);
        chk(done_irq, 1'b0);
        compare_level <= 1'b1;
        run(32'h40, 2000);
        chk(done_irq, 1'b1);
        apb(1'b1, OFF_AUX, 32'h4);
        run(32'h40, 5000);
        chk(cnt, 16);
        chk(done_irq, 1'b1);
        apb(1'b1, OFF_AUX, 0);
        apb(1'b1, OFF_CONVERTER_CONFIG_ONE, 32'h3);
        run(32'h40, 3000);
        chk(saw_async, 1'b1);
        apb(1'b1, OFF_FIRST_STATUS_CONTROL, 32'h5F);
        chk(async_clock_run, 1'b0);
        apb(1'b1, OFF_CONVERTER_CONFIG_ONE, 0);
        apb(1'b1, OFF_AUX, 32'h100);
        for (int t = 0; t < 2000 && done_irq !== 1'b1; t++) begin
            @(posedge sys_clk);
        end
        apb(1'b0, OFF_FIRST_STATUS_CONTROL, 0);
        chk(rd, 32'hDF);
        for (int k = 0; k < 64; k++) begin
            apb(1'b1, OFF_FIRST_STATUS_CONTROL, 32'(k));
            rsv = (k[4:0] inside {5'h18, 5'h19, 5'h1C}) ||
                (k[5] && (k[4:0] inside {[5'h04:5'h17], 5'h1E}));
            chk(mux_ctrl[7:1], {k[4:0], k[5], rsv});
        end
        apb(1'b0, 8'h20, 0);
        chk(rd, 32'h0);
        chk(err_seen, 1'b1);
        finish_test();
    end
endmodule : accc_ctrl_tb
